//--- hw/cis_pkg.sv
// Behaviour
// R01: the core clock is the chip clock itself, with no divider in between.
// R02: a two-register ALU operation reads, computes and writes back in one cycle.
// R03: each source has its own vector; accept only with own and global enable set.
// R04: lowest vector address wins; reset first, then external request zero.
// R05: vector base select moves vectors to boot start; the boot reset fuse moves reset.
// R06: either boot lock bit may suppress interrupts depending on program counter.
// R07: accepting an interrupt clears the global enable.
// R08: setting global enable inside a handler allows nested interrupts.
// R09: return from interrupt sets the global enable.
// R10: hardware clears a flag-type source's flag when vectoring to it.
// R11: writing one to a flag position clears it; zero leaves it.
// R12: flag events set the flag even while disabled; it holds until served or cleared.
// R13: flags pending while globally disabled are served later in priority order.
// R14: level sources request only while present, with no latch.
// R15: after return, one instruction runs before any pending interrupt.
// R16: handler software saves and restores the status register itself.
// R17: global disable acts at once, even on a request in the same cycle.
// R18: after global enable, the next instruction runs before any interrupt.
// R19: entry takes four cycles, pushes the program counter, waits for instruction end.
// R20: return takes four cycles, pops two bytes, adds two to stack pointer.
// R21: entry from sleep takes four extra cycles.
// R22: priority is evaluated at each instruction boundary, lowest index winning.
package cis_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAG = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_SP_LOW = 8'h10;
  localparam logic [7:0] ADDR_SP_HIGH = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_VSEL_BIT = 1;
  localparam int SP_W = 11;
  localparam int SP_HIGH_W = 3;
  localparam logic [SP_W-1:0] SP_RESET = 11'h000;
  localparam logic [SP_W-1:0] SP_PC_BYTES = 11'h002;
  localparam int PC_W = 13;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int ENTRY_CYC = 4;
  localparam int WAKE_CYC = 4;
  localparam int RET_CYC = 4;
  localparam int CNT_W = 4;
  // ==========================================================
  // types
  typedef enum logic [1:0]
  {
    OP_NONE = 2'b00,
    OP_SEI = 2'b01,
    OP_CLI = 2'b10,
    OP_RET_INT = 2'b11
  } cis_op_e;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_RET = 2'b10
  } cis_state_e;
endpackage

//--- hw/cis_prio.sv
module cis_prio
  import cis_pkg::*;
#(
  parameter int N = 8,
  parameter int IW = 3
)
(
  input wire logic [N-1:0] i_req,
  output logic o_valid,
  output logic [IW-1:0] o_idx
);
  // scan downward so the lowest index is assigned last and wins
  always_comb
  begin
    o_valid = 1'b0;
    o_idx = '0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (i_req[k])
      begin
        o_valid = 1'b1;
        o_idx = IW'(k); // see R04
      end
    end
  end
endmodule

//--- hw/cis_alu.sv
module cis_alu
  import cis_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_sub,
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  output logic [W-1:0] o_res
);
  logic [W-1:0] res_d;
  always_comb
  begin
    res_d = i_sub ? W'(i_a - i_b) : W'(i_a + i_b);
  end
  // operands read, result computed and written in the same edge
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_res <= '0;
    else if (i_go)
      o_res <= res_d; // see R02
  end
endmodule

//--- hw/cis_intseq.sv
// Chosen here: the APB slave port and the address map.
module cis_intseq
  import cis_pkg::*;
#(
  parameter int NF = 6,
  parameter int NL = 2,
  parameter int VEC_WORDS = 2,
  parameter logic [PC_W-1:0] BOOT_START = 13'h1C00
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [NF-1:0] I_FLAG_EVT,
  input wire logic [NL-1:0] I_LEVEL_REQ,
  input wire logic I_INSTR_DONE,
  input wire logic [1:0] I_INSTR_OP,
  input wire logic I_SLEEPING,
  input wire logic [PC_W-1:0] I_PC,
  input wire logic I_APP_BOOT_LOCK_BIT,
  input wire logic I_BOOT_SECT_LOCK_BIT,
  input wire logic I_BOOT_RESET_VECTOR_FUSE,
  input wire logic I_ALU_GO,
  input wire logic I_ALU_SUB,
  input wire logic [7:0] I_ALU_A,
  input wire logic [7:0] I_ALU_B,
  output logic [7:0] O_ALU_RES,
  output logic O_VEC_VALID,
  output logic [PC_W-1:0] O_VEC_ADDR,
  output logic [PC_W-1:0] O_RESET_VEC,
  output logic O_ENTRY_BUSY,
  output logic O_RET_BUSY,
  output logic O_GIE,
  output logic [SP_W-1:0] O_SP
);
  localparam int N = NF + NL;
  localparam int IW = $clog2(N);

  // ==========================================================
  // state
  cis_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic gie_q;
  logic vsel_q;
  logic [NF-1:0] flag_q;
  logic [NF-1:0] flag_d;
  logic [NF-1:0] en_flag_q;
  logic [NL-1:0] en_lvl_q;
  logic [IW-1:0] win_q;
  logic [SP_W-1:0] sp_q;
  logic [2:0] lock_s1_q;
  logic [2:0] lock_s2_q;
  logic [N-1:0] req;
  logic req_any;
  logic [IW-1:0] req_idx;
  logic in_boot;
  logic suppress;
  logic accept;
  logic ret_start;
  logic wr;
  logic rd;
  logic [NF-1:0] w1c;
  logic [NF-1:0] hw_clr;

  // ==========================================================
  // apb decode
  // one wait state: pready rises in the second access cycle
  assign wr = I_PSEL & I_PENABLE & I_PWRITE & ~O_PREADY;
  assign rd = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CTRL) || (a == ADDR_FLAG) || (a == ADDR_ENABLE) ||
      (a == ADDR_LEVEL) || (a == ADDR_SP_LOW) || (a == ADDR_SP_HIGH) ||
      (a == ADDR_STATUS);
  endfunction

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~is_mapped(I_PADDR);
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      O_PRDATA <= '0;
    else if (rd)
    begin
      case (I_PADDR)
        ADDR_CTRL:
          O_PRDATA <= {30'h0, vsel_q, gie_q};
        ADDR_FLAG:
          O_PRDATA <= 32'(flag_q);
        ADDR_ENABLE:
          O_PRDATA <= 32'({en_lvl_q, en_flag_q});
        ADDR_LEVEL:
          O_PRDATA <= 32'(I_LEVEL_REQ);
        ADDR_SP_LOW:
          O_PRDATA <= 32'(sp_q[7:0]);
        ADDR_SP_HIGH:
          O_PRDATA <= 32'(sp_q[SP_W-1:8]);
        ADDR_STATUS:
          O_PRDATA <= {16'h0, 8'(win_q), 6'h0, state_q};
        default:
          O_PRDATA <= '0;
      endcase
    end
  end

  // ==========================================================
  // boot lock pins through two flops before use
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      lock_s1_q <= '0;
      lock_s2_q <= '0;
    end
    else
    begin
      lock_s1_q <= {I_BOOT_RESET_VECTOR_FUSE, I_BOOT_SECT_LOCK_BIT, I_APP_BOOT_LOCK_BIT};
      lock_s2_q <= lock_s1_q;
    end
  end

  // running from the section that the vectors do not sit in is unsafe when locked
  assign in_boot = (I_PC >= BOOT_START);
  assign suppress = (lock_s2_q[0] & ~in_boot & vsel_q) |
    (lock_s2_q[1] & in_boot & ~vsel_q); // see R06

  // ==========================================================
  // request gathering and selection
  assign req = {I_LEVEL_REQ & en_lvl_q, flag_q & en_flag_q}; // see R03 see R14

  cis_prio #(.N(N), .IW(IW)) u_prio
  (
    .i_req(req),
    .o_valid(req_any),
    .o_idx(req_idx)
  );

  // only at an instruction end, so multi-cycle instructions finish first
  assign accept = (state_q == ST_IDLE) & I_INSTR_DONE & gie_q & req_any &
    (I_INSTR_OP != OP_CLI) & (I_INSTR_OP != OP_SEI) & ~suppress; // see R17 see R18 see R22
  assign ret_start = (state_q == ST_IDLE) & I_INSTR_DONE & (I_INSTR_OP == OP_RET_INT) &
    ~accept;

  // ==========================================================
  // flags: set beats every clear
  always_comb
  begin
    w1c = (wr && I_PADDR == ADDR_FLAG) ? I_PWDATA[NF-1:0] : '0; // see R11
    hw_clr = '0;
    if (accept && 32'(req_idx) < NF)
      hw_clr[req_idx] = 1'b1; // see R10
    flag_d = (flag_q & ~w1c & ~hw_clr) | I_FLAG_EVT; // see R12 see R13
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      flag_q <= '0;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      en_flag_q <= '0;
      en_lvl_q <= '0;
    end
    else if (wr && I_PADDR == ADDR_ENABLE)
    begin
      en_flag_q <= I_PWDATA[NF-1:0];
      en_lvl_q <= I_PWDATA[N-1:NF];
    end
  end

  // ==========================================================
  // global enable and vector base
  // the status register is not stacked; handlers save it themselves (R16)
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      gie_q <= 1'b0;
    else if (accept)
      gie_q <= 1'b0; // see R07
    else if (I_INSTR_DONE && I_INSTR_OP == OP_CLI)
      gie_q <= 1'b0; // see R17
    else if (I_INSTR_DONE && I_INSTR_OP == OP_SEI)
      gie_q <= 1'b1; // see R18
    else if (state_q == ST_RET && cnt_q == '0)
      gie_q <= 1'b1; // see R09
    else if (wr && I_PADDR == ADDR_CTRL)
      gie_q <= I_PWDATA[CTRL_GIE_BIT]; // see R08
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      vsel_q <= 1'b0;
    else if (wr && I_PADDR == ADDR_CTRL)
      vsel_q <= I_PWDATA[CTRL_VSEL_BIT];
  end

  // ==========================================================
  // entry and return sequencer
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      win_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (accept)
          begin
            state_q <= ST_ENTRY;
            win_q <= req_idx; // see R04
            cnt_q <= I_SLEEPING ? CNT_W'(ENTRY_CYC + WAKE_CYC - 1) :
              CNT_W'(ENTRY_CYC - 1); // see R19 see R21
          end
          else if (ret_start)
          begin
            state_q <= ST_RET;
            cnt_q <= CNT_W'(RET_CYC - 1); // see R20
          end
        end
        ST_ENTRY, ST_RET:
        begin
          // leaving to idle means the next accept needs a fresh instruction end
          if (cnt_q == '0)
            state_q <= ST_IDLE; // see R15
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // stack pointer: push at entry, pop at return end
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      sp_q <= SP_RESET;
    else if (accept)
      sp_q <= sp_q - SP_PC_BYTES; // see R19
    else if (state_q == ST_RET && cnt_q == '0)
      sp_q <= sp_q + SP_PC_BYTES; // see R20
    else if (wr && I_PADDR == ADDR_SP_LOW)
      sp_q[7:0] <= I_PWDATA[7:0];
    else if (wr && I_PADDR == ADDR_SP_HIGH)
      sp_q[SP_W-1:8] <= I_PWDATA[SP_HIGH_W-1:0];
  end

  // ==========================================================
  // outputs
  // the core clock is this clock with no divider, so cycle counts are exact
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_VEC_VALID <= 1'b0;
      O_VEC_ADDR <= '0;
      O_RESET_VEC <= '0;
      O_ENTRY_BUSY <= 1'b0;
      O_RET_BUSY <= 1'b0;
      O_GIE <= 1'b0;
      O_SP <= SP_RESET;
    end
    else
    begin
      O_VEC_VALID <= (state_q == ST_ENTRY) && (cnt_q == '0); // see R01
      O_VEC_ADDR <= (vsel_q ? BOOT_START : '0) +
        PC_W'((32'(win_q) + 1) * VEC_WORDS); // see R03 see R05
      O_RESET_VEC <= lock_s2_q[2] ? BOOT_START : '0; // see R05
      O_ENTRY_BUSY <= (state_q == ST_ENTRY);
      O_RET_BUSY <= (state_q == ST_RET);
      O_GIE <= gie_q;
      O_SP <= sp_q;
    end
  end

  cis_alu #(.W(8)) u_alu
  (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_go(I_ALU_GO),
    .i_sub(I_ALU_SUB),
    .i_a(I_ALU_A),
    .i_b(I_ALU_B),
    .o_res(O_ALU_RES)
  );

  // ==========================================================
  // assertions
  sequence s_entry4;
    (state_q == ST_ENTRY)[*4] ##1 (state_q == ST_IDLE && O_ENTRY_BUSY);
  endsequence
  sequence s_ret4;
    (state_q == ST_RET)[*4] ##1 (state_q == ST_IDLE && gie_q);
  endsequence

  AST_CLI_BLOCKS: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R17
    (I_INSTR_DONE && I_INSTR_OP == OP_CLI) |=> (state_q != ST_ENTRY && !gie_q))
    else $error("interrupt taken or enable kept after disable");
  AST_ENTRY_GIE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R07
    accept |=> !gie_q && state_q == ST_ENTRY)
    else $error("global enable not cleared on entry");
  AST_ENTRY_LEN: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R19
    (accept && !I_SLEEPING) |=> s_entry4 ##0 O_VEC_VALID)
    else $error("entry did not last four cycles");
  AST_WAKE_LEN: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R21
    (accept && I_SLEEPING) |=> (state_q == ST_ENTRY)[*8] ##1 O_VEC_VALID)
    else $error("wake entry did not last eight cycles");
  AST_RET_LEN: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R20
    ret_start |=> s_ret4 ##0 (sp_q == $past(sp_q) + SP_PC_BYTES))
    else $error("return length, enable or stack pointer wrong");
  AST_SP_PUSH: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R19
    accept |=> sp_q == $past(sp_q) - SP_PC_BYTES)
    else $error("stack pointer not pushed by two");
  AST_NEED_GIE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R03
    accept |-> gie_q && req[req_idx])
    else $error("accepted without both enables");
  AST_FLAG_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R12
    (flag_q[0] && !w1c[0] && !hw_clr[0]) |=> flag_q[0])
    else $error("flag lost without clear");
  AST_W1C: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R11
    (w1c[0] && !I_FLAG_EVT[0]) |=> !flag_q[0])
    else $error("write one did not clear flag");
  AST_HW_CLR: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // see R10
    (accept && req_idx == '0 && !I_FLAG_EVT[0]) |=> !flag_q[0] && win_q == '0)
    else $error("served flag not cleared");
endmodule

//--- test/cis_cpu_model.sv
module cis_cpu_model
  import cis_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_step,
  input wire logic [1:0] i_op,
  input wire logic i_vec_valid,
  input wire logic [PC_W-1:0] i_vec_addr,
  output logic o_done,
  output logic [1:0] o_op,
  output logic [PC_W-1:0] o_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // instruction boundaries
  // a boundary comes only when asked, so a long instruction ends before entry
  // no status is stacked here: saving it is handler work
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_done <= 1'b0;
      o_op <= 2'h0;
    end
    else
    begin
      o_done <= i_step;
      // op is only qualified by done, so it wanders otherwise
      o_op <= i_step ? i_op : ~o_op;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_pc <= 13'h0000;
    else if (i_vec_valid)
      o_pc <= i_vec_addr;
    else if (o_done)
      o_pc <= o_pc + 13'h0001;
  end
endmodule

//--- test/cis_intseq_test.sv
module cis_intseq_test
  import cis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int VW = 2;
  localparam logic [12:0] BOOT = 13'h1C00;
  logic clk, rst, psel, pen, pwr, step, slp, go, sub, fuse, pready, pslverr, lk0, lk1;
  logic done, vv, eb, rb, gie, er;
  logic [7:0] paddr, alu_a, alu_b, res;
  logic [31:0] pwdata, prdata, rd, seed, x;
  logic [5:0] fev;
  logic [1:0] lreq, op, cop;
  logic [12:0] pc, va, rv;
  logic [10:0] sp_o;
  int n_errors, check_count, flags, sp, base, m;
  // ==========================================================
  // design and far side
  cis_intseq #(.NF(6), .NL(2), .VEC_WORDS(VW), .BOOT_START(BOOT)) i_cis_intseq (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FLAG_EVT(fev), .I_LEVEL_REQ(lreq), .I_INSTR_DONE(done),
    .I_INSTR_OP(cop), .I_SLEEPING(slp), .I_PC(pc), .I_APP_BOOT_LOCK_BIT(lk0),
    .I_BOOT_SECT_LOCK_BIT(lk1), .I_BOOT_RESET_VECTOR_FUSE(fuse), .I_ALU_GO(go),
    .I_ALU_SUB(sub), .I_ALU_A(alu_a), .I_ALU_B(alu_b), .O_ALU_RES(res),
    .O_VEC_VALID(vv), .O_VEC_ADDR(va), .O_RESET_VEC(rv), .O_ENTRY_BUSY(eb),
    .O_RET_BUSY(rb), .O_GIE(gie), .O_SP(sp_o));
  cis_cpu_model i_cis_cpu_model (
    .i_clk(clk), .i_rst(rst), .i_step(step), .i_op(op), .i_vec_valid(vv),
    .i_vec_addr(va), .o_done(done), .o_op(cop), .o_pc(pc));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic lose();
    n_errors++;
    stop_test();
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      lose();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, 32'h0);
  endtask
  task automatic instr(input logic [1:0] o, input logic s);
    @(posedge clk);
    step <= 1'b1;
    op <= o;
    slp <= s;
    @(posedge clk);
    step <= 1'b0;
  endtask
  task automatic novec();
    repeat (10)
    begin
      @(negedge clk);
      chk({31'h0, vv}, 32'h0);
    end
  endtask
  // one whole entry, handler check and return, against the bench model
  task automatic serve(input int idx, input logic s);
    int n;
    instr(OP_NONE, s);
    for (n = 1; n < 20; n++)
    begin
      @(negedge clk);
      if (vv === 1'b1)
        break;
    end
    if (n == 20)
      lose();
    chk(n, s ? ENTRY_CYC + WAKE_CYC + 2 : ENTRY_CYC + 2);
    chk(eb, 1);
    chk(va, base + (idx + 1) * VW);
    chk(gie, 0);
    sp -= 2;
    chk(sp_o, sp);
    flags &= ~(1 << idx);
    rchk(ADDR_FLAG, flags);
    rchk(ADDR_STATUS, idx << 8);
    instr(OP_RET_INT, 1'b0);
    repeat (3) @(negedge clk);
    chk(rb, 1);
    chk(gie, 0);
    repeat (5) @(negedge clk);
    sp += 2;
    chk(gie, 1);
    chk(sp_o, sp);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    {psel, pen, pwr, step, slp, go, sub, fuse, lk0, lk1} = 10'h000;
    {paddr, alu_a, alu_b, fev, lreq, op} = 34'h0;
    pwdata = 32'h0;
    seed = 32'h50BE;
    n_errors = 0;
    check_count = 0;
    base = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(sp_o, 0);
    for (int i = 0; i < 7; i++)
      rchk(8'(i * 4), 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_SP_LOW, 32'hFF);
    apb(1'b1, ADDR_SP_HIGH, 32'hFF);
    rchk(ADDR_SP_HIGH, 32'h7);
    chk(sp_o, 11'h7FF);
    apb(1'b1, ADDR_SP_LOW, 32'h40);
    apb(1'b1, ADDR_SP_HIGH, 32'h1);
    sp = 'h140;
    flags = xs() & 32'h3F;
    @(posedge clk) fev <= flags[5:0];
    @(posedge clk) fev <= 6'h00;
    rchk(ADDR_FLAG, flags);
    m = (xs() & 32'h3F) | 32'h1;
    apb(1'b1, ADDR_FLAG, m);
    flags &= ~m;
    rchk(ADDR_FLAG, flags);
    @(posedge clk) fev <= 6'h3F;
    @(posedge clk) fev <= 6'h00;
    flags = 'h3F;
    apb(1'b1, ADDR_ENABLE, 32'hFF);
    instr(OP_NONE, 1'b0);
    novec();
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      if (k == 3)
      begin
        apb(1'b1, ADDR_CTRL, 32'h3);
        base = BOOT;
      end
      serve(k, k == 1);
    end
    rchk(ADDR_CTRL, 32'h3);
    @(posedge clk) fev <= 6'h04;
    @(posedge clk) fev <= 6'h00;
    flags = 'h4;
    instr(OP_CLI, 1'b0);
    novec();
    chk(gie, 0);
    instr(OP_SEI, 1'b0);
    novec();
    chk(gie, 1);
    serve(2, 1'b0);
    apb(1'b1, ADDR_ENABLE, 32'h3F);
    @(posedge clk) lreq <= 2'h1;
    rchk(ADDR_LEVEL, 32'h1);
    @(posedge clk) lreq <= 2'h0;
    apb(1'b1, ADDR_ENABLE, 32'hFF);
    instr(OP_NONE, 1'b0);
    novec();
    @(posedge clk) lreq <= 2'h2;
    serve(7, 1'b0);
    @(posedge clk) lreq <= 2'h0;
    // a locked section away from the vectors takes no interrupt
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) {lk1, lk0} <= k ? 2'h1 : 2'h2;
      apb(1'b1, ADDR_CTRL, k ? 32'h3 : 32'h1);
      @(posedge clk) fev <= 6'h01;
      @(posedge clk) fev <= 6'h00;
      flags = 'h1;
      instr(OP_NONE, 1'b0);
      novec();
      @(posedge clk) {lk1, lk0} <= 2'h0;
      base = k ? BOOT : 0;
      serve(0, 1'b0);
    end
    fuse <= 1'b1;
    repeat (4) @(negedge clk);
    chk(rv, BOOT);
    for (int k = 0; k < 4; k++)
    begin
      x = xs();
      @(posedge clk);
      go <= 1'b1;
      alu_a <= x[7:0];
      alu_b <= x[15:8];
      sub <= x[16];
      @(posedge clk) go <= 1'b0;
      @(negedge clk);
      chk(res, x[16] ? 8'(x[7:0] - x[15:8]) : 8'(x[7:0] + x[15:8]));
    end
    stop_test();
  end
endmodule
